// *** rtl/lbs_defs.vh ***
// shared constants of the lcd bank select and flash_rate_command block
`ifndef LBS_DEFS_VH
`define LBS_DEFS_VH

// drive modes
`define LBS_MODE_STATIC 2'h0
`define LBS_MODE_MUX2 2'h1
`define LBS_MODE_MUX3 2'h2
`define LBS_MODE_MUX4 2'h3

// flash rate codes
`define LBS_FLASH_OFF 2'h0
`define LBS_FLASH_2HZ 2'h1
`define LBS_FLASH_1HZ 2'h2
`define LBS_FLASH_05HZ 2'h3

// display clock ratios
`define LBS_FRAME_DIV 12'h018
`define LBS_FLASH_DIV_2HZ 12'h300
`define LBS_FLASH_DIV_1HZ 12'h600
`define LBS_FLASH_DIV_05HZ 12'hC00

// phase lengths in display clock ticks (frame divided by phase count)
`define LBS_PHASE_LEN_STATIC 12'h018
`define LBS_PHASE_LEN_MUX2 12'h00C
`define LBS_PHASE_LEN_MUX3 12'h008
`define LBS_PHASE_LEN_MUX4 12'h006

// last phase index per mode
`define LBS_LAST_STATIC 2'h0
`define LBS_LAST_MUX2 2'h1
`define LBS_LAST_MUX3 2'h2
`define LBS_LAST_MUX4 2'h3

// alternate bank bit offset
`define LBS_BANK_OFS 2'h2

// ram geometry
`define LBS_RAM_WORDS 60
`define LBS_RAM_BITS 4
`define LBS_BYTE_BITS 8

// default internal display clock divider
`define LBS_INT_OSC_DIV 12'h010

`endif

// *** rtl/lbs_sync2.v ***
// two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none

module lbs_sync2 #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // level in and out
  input wire d,
  output wire q
);

  reg meta_q;
  reg sync_q;

  // first stage feeds only the second stage
  always @(posedge ref_clk) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // lbs_sync2

`default_nettype wire

// *** rtl/lbs_tick_div.v ***
// divider that pulses once every div enabled cycles
`timescale 1ns/100ps
`default_nettype none

module lbs_tick_div #(
  parameter W = 12
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // control
  input wire en,
  input wire clr,
  input wire [W-1:0] div,
  // one cycle pulse
  output wire tick
);

  reg [W-1:0] cnt_q;
  reg [W-1:0] cnt_d;
  wire at_end;

  assign at_end = (cnt_q >= (div - {{(W-1){1'b0}}, 1'b1}));
  assign tick = en & at_end & ~clr;

  always @* begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = {W{1'b0}};
    end else if (en) begin
      if (at_end) begin
        cnt_d = {W{1'b0}};
      end else begin
        cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_q <= {W{1'b0}};
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // lbs_tick_div

`default_nettype wire

// *** rtl/lbs_bank_flash_rate_command.v ***
// display ram, output bank selector, input bank selector and blinker
//
// Functional notes
// - one ram bit per word latched each phase
// - four-way mux steps bits 0,1,2,3
// - three-way mux steps bits 0,1,2 only
// - two-way alternates 0,1; static shows bit 0
// - sync forces sequence to its last step
// - static alternate output bank shows bit 2
// - two-way alternate output bank shows bits 2,3
// - alternate input bank writes bit 2 or 2,3
// - input and output bank choices independent
// - flash off or clock divided 768/1536/3072
// - alternate-bank flash swaps banks at rate
// - bank swap only in static and two-way
// - frame is display clock divided by 24
// - ram bit one drives segment on
// - static byte spreads over eight addresses
`timescale 1ns/100ps
`default_nettype none
`include "lbs_defs.vh"

module lbs_bank_flash_rate_command #(
  parameter NWORDS = `LBS_RAM_WORDS,
  parameter DIVW = 12,
  parameter [11:0] INT_OSC_DIV = `LBS_INT_OSC_DIV
) (
  // clock and reset
  input wire ref_clk,
  input wire nrst,
  // display clock source pins
  input wire ext_clk_sel,
  input wire ext_clk,
  // cascade sync pin, active low
  input wire sync_n,
  // mode setting
  input wire [1:0] drive_mode,
  input wire display_enable,
  // bank choice command
  input wire bank_cmd_valid,
  input wire bank_in_alt,
  input wire bank_out_alt,
  // flash command
  input wire flash_rate_command_valid,
  input wire [1:0] flash_rate,
  input wire flash_alt_bank,
  // display data write
  input wire wr_valid,
  input wire [5:0] wr_addr,
  input wire [7:0] wr_byte,
  // display latch and phase
  output wire [NWORDS-1:0] seg_on,
  output wire [1:0] bp_phase,
  output wire phase_strobe,
  output wire flash_state
);

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  wire ext_clk_s;
  wire ext_sel_s;
  wire sync_n_s;
  reg ext_clk_prev_q;

  lbs_sync2 #(.RST_VAL(1'b0)) u_sync_clk (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(ext_clk),
    .q(ext_clk_s)
  );

  lbs_sync2 #(.RST_VAL(1'b0)) u_sync_sel (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(ext_clk_sel),
    .q(ext_sel_s)
  );

  lbs_sync2 #(.RST_VAL(1'b1)) u_sync_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d(sync_n),
    .q(sync_n_s)
  );

  wire sync_act;
  assign sync_act = ~sync_n_s;

  // ***************************************************************
  // display clock tick
  // ***************************************************************
  // the external clock is oversampled, so it must stay below ref_clk/2
  wire int_tick;
  wire ext_tick;
  wire disp_tick;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      ext_clk_prev_q <= 1'b0;
    end else begin
      ext_clk_prev_q <= ext_clk_s;
    end
  end

  assign ext_tick = ext_clk_s & ~ext_clk_prev_q;

  lbs_tick_div #(.W(DIVW)) u_int_osc (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .en(1'b1),
    .clr(1'b0),
    .div(INT_OSC_DIV),
    .tick(int_tick)
  );

  assign disp_tick = ext_sel_s ? ext_tick : int_tick;

  // ***************************************************************
  // command registers
  // ***************************************************************
  reg in_alt_q;
  reg out_alt_q;
  reg [1:0] flash_rate_q;
  reg flash_alt_q;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      in_alt_q <= 1'b0;
      out_alt_q <= 1'b0;
      flash_rate_q <= `LBS_FLASH_OFF;
      flash_alt_q <= 1'b0;
    end else begin
      if (bank_cmd_valid) begin
        in_alt_q <= bank_in_alt;
        out_alt_q <= bank_out_alt;
      end
      if (flash_rate_command_valid) begin
        flash_rate_q <= flash_rate;
        flash_alt_q <= flash_alt_bank;
      end
    end
  end

  // ***************************************************************
  // phase sequencer
  // ***************************************************************
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg [1:0] last_phase;
  reg [DIVW-1:0] phase_len;
  wire phase_tick;

  always @* begin
    case (drive_mode)
      `LBS_MODE_STATIC: begin
        last_phase = `LBS_LAST_STATIC;
        phase_len = `LBS_PHASE_LEN_STATIC;
      end
      `LBS_MODE_MUX2: begin
        last_phase = `LBS_LAST_MUX2;
        phase_len = `LBS_PHASE_LEN_MUX2;
      end
      `LBS_MODE_MUX3: begin
        last_phase = `LBS_LAST_MUX3;
        phase_len = `LBS_PHASE_LEN_MUX3;
      end
      default: begin
        last_phase = `LBS_LAST_MUX4;
        phase_len = `LBS_PHASE_LEN_MUX4;
      end
    endcase
  end

  // phases of one frame add up to 24 display clocks
  lbs_tick_div #(.W(DIVW)) u_phase_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .en(disp_tick),
    .clr(sync_act),
    .div(phase_len),
    .tick(phase_tick)
  );

  always @* begin
    phase_d = phase_q;
    if (sync_act) begin
      phase_d = last_phase;
    end else if (phase_tick) begin
      if (phase_q >= last_phase) begin
        phase_d = 2'h0;
      end else begin
        phase_d = phase_q + 2'h1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_d;
    end
  end

  // ***************************************************************
  // blinker
  // ***************************************************************
  // state toggles each half period, so one full cycle spans the ratio
  reg [DIVW-1:0] flash_div;
  reg flash_q;
  wire flash_half;
  wire flash_on;

  always @* begin
    case (flash_rate_q)
      `LBS_FLASH_2HZ: flash_div = `LBS_FLASH_DIV_2HZ >> 1;
      `LBS_FLASH_1HZ: flash_div = `LBS_FLASH_DIV_1HZ >> 1;
      `LBS_FLASH_05HZ: flash_div = `LBS_FLASH_DIV_05HZ >> 1;
      default: flash_div = `LBS_FLASH_DIV_2HZ >> 1;
    endcase
  end

  assign flash_on = (flash_rate_q != `LBS_FLASH_OFF);

  lbs_tick_div #(.W(DIVW)) u_flash_div (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .en(disp_tick),
    .clr(~flash_on),
    .div(flash_div),
    .tick(flash_half)
  );

  always @(posedge ref_clk) begin
    if (!nrst) begin
      flash_q <= 1'b0;
    end else if (!flash_on) begin
      flash_q <= 1'b0;
    end else if (flash_half) begin
      flash_q <= ~flash_q;
    end
  end

  assign flash_state = flash_q;

  // ***************************************************************
  // output bank selector
  // ***************************************************************
  // only static and two-way have a spare bank to swap with
  wire has_spare;
  wire swap_now;
  wire blank_now;
  wire out_bank;
  wire [1:0] sel_bit;

  assign has_spare = (drive_mode == `LBS_MODE_STATIC) | (drive_mode == `LBS_MODE_MUX2);
  assign swap_now = flash_alt_q & flash_q & has_spare;
  assign blank_now = ~flash_alt_q & flash_q;
  assign out_bank = has_spare & (out_alt_q ^ swap_now);
  assign sel_bit = phase_d + (out_bank ? `LBS_BANK_OFS : 2'h0);

  // ***************************************************************
  // display ram and input bank selector
  // ***************************************************************
  reg [NWORDS*4-1:0] ram_q;
  reg [NWORDS*4-1:0] ram_d;
  integer a;
  integer b;
  integer k;
  integer idx;
  integer ib;
  reg hit;

  always @* begin
    ram_d = ram_q;
    k = 0;
    idx = 0;
    hit = 1'b0;
    ib = (in_alt_q && (drive_mode == `LBS_MODE_STATIC || drive_mode == `LBS_MODE_MUX2))
      ? `LBS_BANK_OFS : 0;
    for (a = 0; a < NWORDS; a = a + 1) begin
      for (b = 0; b < `LBS_RAM_BITS; b = b + 1) begin
        k = a - wr_addr;
        hit = 1'b0;
        idx = 0;
        case (drive_mode)
          `LBS_MODE_STATIC: begin
            hit = (b == ib) && (k >= 0) && (k < `LBS_BYTE_BITS);
            idx = k;
          end
          `LBS_MODE_MUX2: begin
            hit = (b >= ib) && (b < ib + 2) && (k >= 0) && (k < 4);
            idx = k * 2 + (b - ib);
          end
          `LBS_MODE_MUX3: begin
            hit = (b < 3) && (k >= 0) && (k < 3) && (k * 3 + b < 8);
            idx = k * 3 + b;
          end
          default: begin
            hit = (k >= 0) && (k < 2);
            idx = k * 4 + b;
          end
        endcase
        if (wr_valid && hit) begin
          // first transmitted bit is the msb
          ram_d[a*4+b] = wr_byte[`LBS_BYTE_BITS-1-idx];
        end
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      ram_q <= {NWORDS*4{1'b0}};
    end else begin
      ram_q <= ram_d;
    end
  end

  // ***************************************************************
  // display latch
  // ***************************************************************
  reg [NWORDS-1:0] seg_q;
  reg [1:0] bp_q;
  reg strobe_q;
  reg sync_prev_q;
  integer s;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      seg_q <= {NWORDS{1'b0}};
      bp_q <= 2'h0;
      strobe_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      // a held sync relatches every cycle but strobes only on its first cycle
      sync_prev_q <= sync_act;
      strobe_q <= phase_tick | (sync_act & ~sync_prev_q);
      if (phase_tick || sync_act) begin
        bp_q <= phase_d;
        for (s = 0; s < NWORDS; s = s + 1) begin
          seg_q[s] <= ram_q[s*4+sel_bit] & display_enable & ~blank_now;
        end
      end
    end
  end

  assign seg_on = seg_q;
  assign bp_phase = bp_q;
  assign phase_strobe = strobe_q;

endmodule // lbs_bank_flash_rate_command

`default_nettype wire

// *** verif/lbs_glass.sv ***
// lcd glass model for the bank select and flash block
`timescale 1ns/100ps
`default_nettype none
module lbs_glass (
  // clock
  input wire logic ref_clk,
  // drive from the block
  input wire logic [59:0] seg_on,
  input wire logic [1:0] bp_phase,
  input wire logic phase_strobe,
  // what segments 0 and 1 show, and on which backplane
  output logic [1:0] lit_q,
  output logic [1:0] bp_q
);
  // only the strobed column reaches the glass
  always @(posedge ref_clk)
    if (phase_strobe) begin
      lit_q <= seg_on[1:0];
      bp_q <= bp_phase;
    end
endmodule // lbs_glass
`default_nettype wire

// *** verif/lbs_chk_asserts.sv ***
// assertion checker for the bank select and flash block
`timescale 1ns/100ps
`default_nettype none
module lbs_chk #(parameter NWORDS = 60) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // controls
  input wire logic sync_n,
  input wire logic [1:0] drive_mode,
  input wire logic display_enable,
  input wire logic flash_rate_command_valid,
  input wire logic [1:0] flash_rate,
  // outputs
  input wire logic [NWORDS-1:0] seg_on,
  input wire logic [1:0] bp_phase,
  input wire logic phase_strobe,
  input wire logic flash_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_strobe_one: assert property (phase_strobe |=> !phase_strobe)
    else $error("strobe too long");
  // sync edges may relatch, so they are left out
  a_latch_hold: assert property (!phase_strobe && sync_n && $past(sync_n, 4)
    |-> $stable(seg_on) && $stable(bp_phase)) else $error("latch moved");
  a_phase_step: assert property (phase_strobe && bp_phase != 2'h0 && sync_n
    && $past(sync_n, 4) |-> bp_phase == $past(bp_phase) + 2'h1) else $error("bad step");
  a_phase_range: assert property (phase_strobe && $stable(drive_mode)
    |-> bp_phase <= drive_mode) else $error("phase past last");
  a_sync_last: assert property ((!sync_n)[*6] |-> bp_phase == drive_mode)
    else $error("sync not at last");
  a_enable_dark: assert property (phase_strobe && !$past(display_enable)
    && !$past(display_enable, 2) |-> seg_on == '0) else $error("lit while off");
  a_flash_off: assert property (flash_rate_command_valid && flash_rate == 2'h0
    |-> ##2 (!flash_state)[*4]) else $error("flash still on");
  a_reset_clear: assert property (disable iff (1'b0) !nrst |=> seg_on == '0
    && bp_phase == 2'h0 && !flash_state && !phase_strobe) else $error("reset values");
endmodule // lbs_chk
bind lbs_bank_flash_rate_command lbs_chk #(.NWORDS(NWORDS)) i_lbs_chk (.ref_clk, .nrst, .sync_n,
  .drive_mode, .display_enable, .flash_rate_command_valid, .flash_rate, .seg_on,
  .bp_phase, .phase_strobe, .flash_state);
`default_nettype wire

// *** verif/tb.sv ***
// self-checking bench for the bank select and flash block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk, nrst, ext_clk_sel, ext_clk, sync_n, display_enable;
  logic bank_cmd_valid, bank_in_alt, bank_out_alt, wr_valid, phase_strobe;
  logic flash_rate_command_valid, flash_alt_bank, flash_state;
  logic [1:0] drive_mode, flash_rate, bp_phase, lit_q, bp_q;
  logic [5:0] wr_addr;
  logic [7:0] wr_byte;
  logic [59:0] seg_on;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  // short display tick keeps the flash periods cheap
  lbs_bank_flash_rate_command #(.INT_OSC_DIV(12'h002)) i_lbs_bank_flash_rate_command (.ref_clk, .nrst,
    .ext_clk_sel, .ext_clk, .sync_n, .drive_mode, .display_enable, .bank_cmd_valid,
    .bank_in_alt, .bank_out_alt, .flash_rate_command_valid, .flash_rate,
    .flash_alt_bank, .wr_valid, .wr_addr, .wr_byte, .seg_on, .bp_phase,
    .phase_strobe, .flash_state);
  lbs_glass i_lbs_glass (.ref_clk, .seg_on, .bp_phase, .phase_strobe, .lit_q, .bp_q);
  initial begin
    ref_clk = 0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ********
  // helpers
  // ********
  task chk(input logic [11:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task ph(input logic [1:0] p, s);
    repeat (60) begin
      @(negedge ref_clk);
      if (phase_strobe === 1'b1) break;
    end
    chk(phase_strobe, 1'b1);
    @(negedge ref_clk);
    chk(bp_q, p);
    chk(lit_q, s);
  endtask
  task sy(input logic [1:0] m);
    drive_mode = m;
    sync_n = 0;
    repeat (20) @(negedge ref_clk);
    chk(bp_phase, m);
    sync_n = 1;
    repeat (4) @(negedge ref_clk);
  endtask
  task bk(input logic i, o);
    bank_in_alt = i;
    bank_out_alt = o;
    bank_cmd_valid = 1;
    @(negedge ref_clk) bank_cmd_valid = 0;
    @(negedge ref_clk);
  endtask
  task fl(input logic [1:0] r, input logic a);
    flash_rate = r;
    flash_alt_bank = a;
    flash_rate_command_valid = 1;
    @(negedge ref_clk) flash_rate_command_valid = 0;
    @(negedge ref_clk);
  endtask
  task wr(input logic [7:0] b);
    wr_byte = b;
    wr_valid = 1;
    @(negedge ref_clk) wr_valid = 0;
    @(negedge ref_clk);
  endtask
  task fwait(output int n);
    logic v;
    v = flash_state;
    n = 0;
    while (flash_state === v && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(flash_state !== v, 1'b1);
  endtask
  // ********
  // scenarios
  // ********
  task t_static;
    sy(2'h0);
    wr(8'h80);
    bk(1, 0);
    wr(8'h40);
    ph(0, 2'h1);
    bk(0, 1);
    wr(8'hC0);
    ph(0, 2'h2);
    $display("static done");
  endtask
  task t_flash;
    int n;
    fl(1, 1);
    fwait(n);
    ph(0, 2'h3);
    for (int r = 1; r < 4; r++) begin
      fl(0, 0);
      fl(r[1:0], 0);
      fwait(n);
      ph(0, 2'h0);
      fwait(n);
      fwait(n);
      chk(n[11:0], 12'h180 << r);
    end
    fl(0, 0);
    $display("flash done");
  endtask
  task t_mux2;
    bk(0, 0);
    sy(2'h1);
    wr(8'h90);
    ph(0, 2'h1);
    ph(1, 2'h2);
    bk(0, 1);
    ph(0, 2'h2);
    ph(1, 2'h0);
    bk(1, 1);
    wr(8'h30);
    ph(0, 2'h2);
    ph(1, 2'h2);
    $display("mux2 done");
  endtask
  task t_mux4;
    sy(2'h3);
    wr(8'hA5);
    for (int p = 0; p < 4; p++) ph(p[1:0], p[0] ? 2'h2 : 2'h1);
    display_enable = 0;
    ph(0, 2'h0);
    display_enable = 1;
    $display("mux4 done");
  endtask
  task t_mux3;
    sy(2'h2);
    wr(8'hE0);
    for (int p = 0; p < 4; p++) ph(p % 3, 2'h1);
    $display("mux3 done");
  endtask
  // external display clock: a tick every 4 cycles, three-way phase is 8 ticks
  task t_ext;
    int n;
    int m;
    ext_clk_sel = 1;
    n = 0;
    m = 0;
    for (int i = 0; i < 240; i++) begin
      @(negedge ref_clk);
      ext_clk = i[1];
      if (phase_strobe === 1'b1) begin
        if (m >= 2) chk(i - n, 12'h020);
        n = i;
        m++;
      end
    end
    chk(m > 4, 1'b1);
    ext_clk_sel = 0;
    ext_clk = 0;
    $display("ext clock done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ********
  // main
  // ********
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  initial begin
    {nrst, ext_clk_sel, ext_clk, bank_cmd_valid, bank_in_alt, bank_out_alt} = '0;
    {flash_rate_command_valid, flash_alt_bank, flash_rate, drive_mode} = '0;
    {wr_valid, wr_addr, wr_byte} = '0;
    sync_n = 1;
    display_enable = 1;
    repeat (3) @(negedge ref_clk);
    nrst = 1;
    chk({flash_state, bp_phase, seg_on[8:0]}, 12'h000);
    t_static;
    t_flash;
    t_mux2;
    bk(0, 1);
    t_mux4;
    t_mux3;
    t_ext;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
